// ---- common/scpx_pkg.sv ----
/*
  scpx_pkg: shared constants and carriers for the soft cpu pipeline and
  exception status block.
  assumes: one processor clock, selector codes 3 bits wide.
*/
package scpx_pkg;
  // special register selectors
  localparam logic [2:0] SEL_EXC_STATUS = 3'h5;
  localparam logic [2:0] SEL_FLOAT_STATUS = 3'h7;
  // exception cause codes
  localparam logic [4:0] CAUSE_NONE = 5'h00;
  localparam logic [4:0] CAUSE_UNALIGNED = 5'h01;
  localparam logic [4:0] CAUSE_ILLEGAL = 5'h02;
  localparam logic [4:0] CAUSE_IBUS = 5'h03;
  localparam logic [4:0] CAUSE_DBUS = 5'h04;
  localparam logic [4:0] CAUSE_DIVZERO = 5'h05;
  localparam logic [4:0] CAUSE_FPU = 5'h06;
  // field positions, msb-0 numbering mapped to lsb-0 vector bits (bit n -> 31-n)
  localparam int CAUSE_LSB = 0;
  localparam int WORD_BIT = 11;
  localparam int STORE_BIT = 10;
  localparam int RX_LSB = 5;
  localparam int FLAG_LSB = 0;
  // reset values and vectors
  localparam logic [31:0] EXC_STATUS_RESET = 32'h0000_0000;
  localparam logic [4:0] FLOAT_FLAGS_RESET = 5'h00;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [31:0] EXC_VECTOR = 32'h0000_0020;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [4:0] EXC_RETURN_REG = 5'h11;
  localparam logic [31:0] INSN_STEP = 32'h0000_0004;
  localparam logic [3:0] NOP_COUNT = 4'h0;

  // data access sizes
  typedef enum logic [1:0] {SCPX_BYTE, SCPX_HALF, SCPX_WORD} scpx_size_t;

  // one executing instruction as delivered by the decoder
  typedef struct packed {
    logic valid;
    logic mem;
    logic store;
    scpx_size_t size;
    logic [4:0] reg_num;
    logic [31:0] addr;
    logic branch_taken;
    logic delay_slot;
    logic [31:0] target;
    logic [3:0] extra_cycles;
    logic illegal;
    logic divzero;
    logic fpu_exc;
    logic [4:0] fpu_flags;
    logic move_to_special;
    logic mfs;
    logic [2:0] sel;
    logic [31:0] wdata;
  } scpx_exec_t;

  // memory request on the three interfaces
  typedef struct packed {
    logic [2:0] start;
    logic [2:0] abort;
    logic [31:0] addr;
    logic store;
    scpx_size_t size;
  } scpx_mem_t;
endpackage : scpx_pkg

// ---- rtl/scpx_core.sv ----
/*
  scpx_core: three stage pipeline control, prefetch buffer, exception
  status and float status registers, speculative data access issue.
  assumes: decoder supplies the execute-stage instruction as a struct,
  memories answer fetches with ifetch_ack, and the address map decode
  outside gives a one-hot interface match a cycle after issue.
*/
`timescale 1ns/1ns
module scpx_core #(
  parameter bit UNALIGNED_EXC = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire scpx_pkg::scpx_exec_t exec_in,
  input wire logic ifetch_ack,
  input wire logic [31:0] ifetch_data,
  input wire logic ibus_err,
  input wire logic dbus_err,
  input wire logic [2:0] bus_match,
  output logic [31:0] ifetch_addr,
  output logic ifetch_req,
  output logic [31:0] decode_insn,
  output logic decode_valid,
  output logic exec_ready,
  output scpx_pkg::scpx_mem_t dmem,
  output logic [31:0] spr_rdata,
  output logic [31:0] exc_status,
  output logic [31:0] exc_address,
  output logic [4:0] float_flags,
  output logic gpr_we,
  output logic [4:0] gpr_waddr,
  output logic [31:0] gpr_wdata
);
  import scpx_pkg::*;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] fetch_insn;
    logic fetch_valid;
    logic [31:0] fetch_pc;
    logic [31:0] dec_insn;
    logic dec_valid;
    logic [31:0] dec_pc;
    logic [31:0] pf_insn;
    logic pf_valid;
    logic [3:0] stall_cnt;
    logic [31:0] exception_status;
    logic [31:0] exception_address;
    logic [4:0] float_status_flags;
    scpx_mem_t dm;
    logic [31:0] rdata;
    logic we;
    logic [4:0] waddr;
    logic [31:0] wdata;
    logic ireq;
    logic ready;
  } scpx_state_t;

  scpx_state_t st_reg;
  scpx_state_t st_next;

  // natural alignment check, shared by issue and exception paths
  function automatic logic scpx_misaligned(input scpx_size_t sz, input logic [1:0] lo);
    scpx_misaligned = (sz == SCPX_WORD && lo != 2'b00) || (sz == SCPX_HALF && lo[0]);
  endfunction : scpx_misaligned

  logic stall;
  logic unaligned;
  logic take_exc;
  logic [4:0] cause;

  // stall while extra execute cycles remain
  assign stall = exec_in.valid && (exec_in.extra_cycles != NOP_COUNT) &&
                 (st_reg.stall_cnt != exec_in.extra_cycles);
  assign unaligned = UNALIGNED_EXC && exec_in.valid && exec_in.mem &&
                     scpx_misaligned(exec_in.size, exec_in.addr[1:0]);

  // cause priority, fixed order
  always_comb begin
    cause = CAUSE_NONE;
    if (ibus_err) begin
      cause = CAUSE_IBUS;
    end else if (exec_in.valid && exec_in.illegal) begin
      cause = CAUSE_ILLEGAL;
    end else if (unaligned) begin
      cause = CAUSE_UNALIGNED;
    end else if (dbus_err) begin
      cause = CAUSE_DBUS;
    end else if (exec_in.valid && exec_in.divzero) begin
      cause = CAUSE_DIVZERO;
    end else if (exec_in.valid && exec_in.fpu_exc) begin
      cause = CAUSE_FPU;
    end
  end
  assign take_exc = (cause != CAUSE_NONE);

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.we = 1'b0;
    st_next.dm.start = 3'b000;
    st_next.dm.abort = 3'b000;
    st_next.ireq = 1'b1;
    // abort speculative accesses that did not match, one cycle after issue
    if (st_reg.dm.start != 3'b000) begin
      st_next.dm.abort = st_reg.dm.start & ~bus_match;
    end
    // multi-cycle counter
    if (stall) begin
      st_next.stall_cnt = st_reg.stall_cnt + 4'h1;
    end else begin
      st_next.stall_cnt = NOP_COUNT;
    end
    // prefetch loads the next sequential word into its one-entry buffer while stalled
    if (stall) begin
      if (!st_reg.pf_valid && ifetch_ack) begin
        st_next.pf_insn = ifetch_data;
        st_next.pf_valid = 1'b1;
        st_next.pc = st_reg.pc + INSN_STEP;
      end
      st_next.ireq = !st_reg.pf_valid;
    end else begin
      // one stage per cycle: decode takes fetch, fetch takes buffer or memory
      st_next.dec_insn = st_reg.fetch_insn;
      st_next.dec_valid = st_reg.fetch_valid;
      st_next.dec_pc = st_reg.fetch_pc;
      if (st_reg.pf_valid) begin
        st_next.fetch_insn = st_reg.pf_insn;
        st_next.fetch_valid = 1'b1;
        st_next.fetch_pc = st_reg.pc - INSN_STEP;
        st_next.pf_valid = 1'b0;
      end else if (ifetch_ack) begin
        st_next.fetch_insn = ifetch_data;
        st_next.fetch_valid = 1'b1;
        st_next.fetch_pc = st_reg.pc;
        st_next.pc = st_reg.pc + INSN_STEP;
      end else begin
        st_next.fetch_valid = 1'b0;
      end
    end
    // execute-stage effects when the instruction finishes
    if (exec_in.valid && !stall && !take_exc) begin
      if (exec_in.mem) begin
        // same path for i/o and memory: issue on every interface at once
        st_next.dm.start = 3'b111;
        st_next.dm.addr = exec_in.addr;
        st_next.dm.store = exec_in.store;
        st_next.dm.size = exec_in.size;
      end
      st_next.float_status_flags = st_reg.float_status_flags | exec_in.fpu_flags;
      if (exec_in.move_to_special && exec_in.sel == SEL_FLOAT_STATUS) begin
        st_next.float_status_flags = exec_in.wdata[FLAG_LSB +: 5] | exec_in.fpu_flags;
      end
      if (exec_in.mfs) begin
        st_next.rdata = EXC_STATUS_RESET;
        if (exec_in.sel == SEL_EXC_STATUS) begin
          st_next.rdata = st_reg.exception_status;
        end else if (exec_in.sel == SEL_FLOAT_STATUS) begin
          st_next.rdata = {27'h000_0000, st_reg.float_status_flags};
        end
      end
      if (exec_in.branch_taken) begin
        // fetch always flushed; decode kept only for a delay slot
        st_next.pc = {exec_in.target[31:2], 2'b00};
        st_next.fetch_valid = 1'b0;
        st_next.pf_valid = 1'b0;
        if (!exec_in.delay_slot) begin
          st_next.dec_valid = 1'b0;
        end
      end
    end
    // exception: record cause and detail, flush, vector, save decode pc
    if (take_exc) begin
      st_next.exception_status = EXC_STATUS_RESET;
      st_next.exception_status[CAUSE_LSB +: 5] = cause;
      if (cause == CAUSE_UNALIGNED) begin
        st_next.exception_status[WORD_BIT] = (exec_in.size == SCPX_WORD);
        st_next.exception_status[STORE_BIT] = exec_in.store;
        st_next.exception_status[RX_LSB +: 5] = exec_in.reg_num;
      end
      if (cause == CAUSE_UNALIGNED) begin
        st_next.exception_address = exec_in.addr;
      end else if (cause == CAUSE_DBUS) begin
        st_next.exception_address = st_reg.dm.addr;
      end
      if (cause == CAUSE_FPU) begin
        st_next.float_status_flags = st_reg.float_status_flags | exec_in.fpu_flags;
      end
      st_next.pc = EXC_VECTOR;
      st_next.fetch_valid = 1'b0;
      st_next.dec_valid = 1'b0;
      st_next.pf_valid = 1'b0;
      st_next.stall_cnt = NOP_COUNT;
      st_next.we = 1'b1;
      st_next.waddr = EXC_RETURN_REG;
      st_next.wdata = st_reg.dec_pc;
    end
    // ready registered so the port comes straight from a flip-flop
    st_next.ready = (st_next.stall_cnt == NOP_COUNT);
  end

  // state register, constants only under reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.pc <= RESET_VECTOR;
      st_reg.exception_status <= EXC_STATUS_RESET;
      st_reg.exception_address <= ADDR_RESET;
      st_reg.float_status_flags <= FLOAT_FLAGS_RESET;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign ifetch_addr = st_reg.pc;
  assign ifetch_req = st_reg.ireq;
  assign decode_insn = st_reg.dec_insn;
  assign decode_valid = st_reg.dec_valid;
  assign exec_ready = st_reg.ready;
  assign dmem = st_reg.dm;
  assign spr_rdata = st_reg.rdata;
  assign exc_status = st_reg.exception_status;
  assign exc_address = st_reg.exception_address;
  assign float_flags = st_reg.float_status_flags;
  assign gpr_we = st_reg.we;
  assign gpr_waddr = st_reg.waddr;
  assign gpr_wdata = st_reg.wdata;

  // aborts only ever follow an issue by one cycle
  property p_abort_follows;
    @(posedge clk) disable iff (!nrst)
      (dmem.abort != 3'b000) |-> ($past(dmem.start) == 3'b111);
  endproperty
  a_abort_follows: assert property (p_abort_follows) else $error("abort without issue");

  property p_issue_all;
    @(posedge clk) disable iff (!nrst)
      (dmem.start != 3'b000) |-> (dmem.start == 3'b111);
  endproperty
  a_issue_all: assert property (p_issue_all) else $error("partial issue");

  property p_fetch_aligned;
    @(posedge clk) disable iff (!nrst) ifetch_addr[1:0] == 2'b00;
  endproperty
  a_fetch_aligned: assert property (p_fetch_aligned) else $error("fetch unaligned");

  property p_exc_vector;
    @(posedge clk) disable iff (!nrst)
      take_exc |=> (ifetch_addr == EXC_VECTOR && gpr_we && gpr_waddr == EXC_RETURN_REG);
  endproperty
  a_exc_vector: assert property (p_exc_vector) else $error("no vector jump");

  property p_cause;
    @(posedge clk) disable iff (!nrst)
      take_exc |=> (exc_status[CAUSE_LSB +: 5] == $past(cause));
  endproperty
  a_cause: assert property (p_cause) else $error("cause not recorded");

  property p_detail_zero;
    @(posedge clk) disable iff (!nrst)
      (take_exc && cause != CAUSE_UNALIGNED) |=> (exc_status[31:5] == 27'h000_0000);
  endproperty
  a_detail_zero: assert property (p_detail_zero) else $error("detail not zero");

  property p_unaligned_no_issue;
    @(posedge clk) disable iff (!nrst)
      unaligned |=> (dmem.start == 3'b000);
  endproperty
  a_unaligned_no_issue: assert property (p_unaligned_no_issue) else $error("unaligned issued");

  property p_flags_sticky;
    @(posedge clk) disable iff (!nrst)
      !(exec_in.valid && exec_in.move_to_special && exec_in.sel == SEL_FLOAT_STATUS)
      |=> ((float_flags & $past(float_flags)) == $past(float_flags));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("flag lost");

  property p_branch_flush;
    @(posedge clk) disable iff (!nrst)
      (exec_in.valid && exec_in.branch_taken && !exec_in.delay_slot && !stall && !take_exc)
      |=> (!decode_valid ##1 !decode_valid);
  endproperty
  a_branch_flush: assert property (p_branch_flush) else $error("decode not flushed");

  property p_stall_hold;
    @(posedge clk) disable iff (!nrst)
      (stall && !take_exc) |=> $stable(decode_insn);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("decode moved in stall");
endmodule : scpx_core

// ---- sim/scpx_mem_model.sv ----
/*
  scpx_mem_model: instruction memory and bus address decode beside the core.
  assumes: fetches are word aligned, data interfaces resolve by the top two
  address bits, slow answers a request only on every other clock cycle.
*/
`timescale 1ns/1ns
module scpx_mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic ifetch_req,
  input wire logic [31:0] ifetch_addr,
  input wire scpx_pkg::scpx_mem_t dmem,
  output logic ifetch_ack,
  output logic [31:0] ifetch_data,
  output logic [2:0] bus_match
);
  import scpx_pkg::*;
  logic phase_reg;
  logic [31:0] last_reg;
  // answer pacing and the word last shown on the fetch data lines
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 1'b0;
      last_reg <= 32'h0000_0000;
    end else begin
      phase_reg <= ~phase_reg;
      last_reg <= ifetch_data;
    end
  end
  // core takes the word for its current address in the same cycle
  assign ifetch_ack = ifetch_req && (!slow || phase_reg);
  // no stale word between answers: show the inverse of the last one
  assign ifetch_data = ifetch_ack ? ({ifetch_addr[31:2], 2'b00} ^ 32'h5A5A_0000) : ~last_reg;
  // disjoint maps: each address hits exactly one interface
  always_comb begin
    bus_match = 3'b000;
    if (dmem.start != 3'b000) begin
      case (dmem.addr[31:30])
        2'b00: bus_match = 3'b001;
        2'b01: bus_match = 3'b010;
        default: bus_match = 3'b100;
      endcase
    end
  end
endmodule : scpx_mem_model

// ---- sim/test_soft_cpu_pipeline_exception_status.sv ----
/*
  test_soft_cpu_pipeline_exception_status: drives execute-stage instructions
  and error pulses, checks status registers, pc redirects and data issue.
  assumes: scpx_pkg and scpx_core compiled first, memory model beside it.
*/
`timescale 1ns/1ns
module test_soft_cpu_pipeline_exception_status;
  import scpx_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic slow = 1'b0;
  logic ibus_err = 1'b0;
  logic dbus_err = 1'b0;
  scpx_exec_t exec_in = '0;
  scpx_exec_t x;
  logic ifetch_ack, ifetch_req, decode_valid, exec_ready, gpr_we;
  logic [31:0] ifetch_data, ifetch_addr, decode_insn, spr_rdata, exc_status, exc_address;
  logic [31:0] gpr_wdata, a;
  logic [2:0] bus_match;
  logic [4:0] float_flags, gpr_waddr;
  scpx_mem_t dmem;
  int n_mismatch = 0;
  int compares = 0;
  int st, k;
  logic [4:0] causes [3] = '{CAUSE_ILLEGAL, CAUSE_DIVZERO, CAUSE_FPU};

  always #10 clk = ~clk;

  scpx_core dut (.clk(clk), .nrst(nrst), .exec_in(exec_in), .ifetch_ack(ifetch_ack),
    .ifetch_data(ifetch_data), .ibus_err(ibus_err), .dbus_err(dbus_err),
    .bus_match(bus_match), .ifetch_addr(ifetch_addr), .ifetch_req(ifetch_req),
    .decode_insn(decode_insn), .decode_valid(decode_valid), .exec_ready(exec_ready),
    .dmem(dmem), .spr_rdata(spr_rdata), .exc_status(exc_status), .exc_address(exc_address),
    .float_flags(float_flags), .gpr_we(gpr_we), .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata));

  scpx_mem_model mem (.clk(clk), .nrst(nrst), .slow(slow), .ifetch_req(ifetch_req),
    .ifetch_addr(ifetch_addr), .dmem(dmem), .ifetch_ack(ifetch_ack),
    .ifetch_data(ifetch_data), .bus_match(bus_match));

  task close_out;
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // hold the instruction through its stall; returns at the negedge after it finishes
  task run(input scpx_exec_t i, output int stalls);
    int n;
    stalls = 0;
    exec_in = i;
    @(negedge clk);
    for (n = 0; n < 40 && exec_ready === 1'b0; n++) begin
      stalls++;
      @(negedge clk);
    end
    if (n == 40) begin
      n_mismatch++;
      close_out();
    end
  endtask : run

  // separate step for the drop, so exec_in never changes twice at one time
  task idle;
    exec_in.valid = 1'b0;
    @(negedge clk);
  endtask : idle

  task exc_chk(input logic [31:0] status);
    chk("exc status", status, exc_status);
    chk("vector", EXC_VECTOR, ifetch_addr);
    chk("return reg", {26'h0, 1'b1, EXC_RETURN_REG}, {26'h0, gpr_we, gpr_waddr});
  endtask : exc_chk

  initial begin
    repeat (6) @(negedge clk);
    chk("fetch in reset", 32'h0000_0000, {31'h0, ifetch_req});
    chk("status reset", 32'h0000_0000, exc_status);
    chk("flags reset", 32'h0000_0000, {27'h0, float_flags});
    nrst = 1'b1;
    @(negedge clk);
    chk("fetch after reset", 32'h0000_0001, {31'h0, ifetch_req});
    repeat (3) @(negedge clk);
    // sequential fetch: one word per cycle with a prompt memory
    a = ifetch_addr;
    @(negedge clk);
    chk("fetch step", a + INSN_STEP, ifetch_addr);
    // aligned load: speculative issue on all three, unmatched aborted next cycle
    x = '0; x.valid = 1'b1; x.mem = 1'b1; x.size = SCPX_WORD; x.addr = 32'h4000_0010;
    run(x, st);
    idle();
    // start was shown at the previous negedge; abort here is ~match of peripheral
    chk("abort", 32'h0000_0005, {29'h0, dmem.abort});
    // stall with a slow memory: prefetch keeps moving
    slow = 1'b1;
    a = ifetch_addr;
    x = '0; x.valid = 1'b1; x.extra_cycles = 4'h3;
    run(x, st);
    chk("prefetch pc", a + INSN_STEP, ifetch_addr);
    idle();
    chk("stall cycles", 32'h0000_0003, st);
    chk("prefetch word", a ^ 32'h5A5A_0000, decode_insn);
    slow = 1'b0;
    // taken branch without and with delay slot
    x = '0; x.valid = 1'b1; x.branch_taken = 1'b1; x.target = 32'h0000_0100;
    run(x, st);
    chk("branch pc", 32'h0000_0100, ifetch_addr);
    chk("decode flushed", 32'h0000_0000, {31'h0, decode_valid});
    idle();
    repeat (3) @(negedge clk);
    x.delay_slot = 1'b1; x.target = 32'h0000_0203;
    run(x, st);
    chk("slot branch pc", 32'h0000_0200, ifetch_addr);
    chk("slot decode kept", 32'h0000_0001, {31'h0, decode_valid});
    idle();
    // sticky float flags, write via the special register path, readback
    x = '0; x.valid = 1'b1; x.fpu_flags = 5'h14;
    run(x, st);
    x.fpu_flags = 5'h01;
    run(x, st);
    idle();
    chk("flags sticky", 32'h0000_0015, {27'h0, float_flags});
    x = '0; x.valid = 1'b1; x.mfs = 1'b1; x.sel = SEL_FLOAT_STATUS;
    run(x, st);
    idle();
    chk("flags read", 32'h0000_0015, spr_rdata);
    x = '0; x.valid = 1'b1; x.move_to_special = 1'b1; x.sel = SEL_FLOAT_STATUS; x.wdata = 32'h0000_0002;
    run(x, st);
    idle();
    chk("flags write", 32'h0000_0002, {27'h0, float_flags});
    // unaligned word store from r5, then halfword load into r3
    x = '0; x.valid = 1'b1; x.mem = 1'b1; x.store = 1'b1; x.size = SCPX_WORD;
    x.reg_num = 5'h05; x.addr = 32'h0000_1002;
    run(x, st);
    exc_chk(32'h0000_0CA1);
    chk("no issue", 32'h0000_0000, {29'h0, dmem.start});
    chk("fault addr", 32'h0000_1002, exc_address);
    idle();
    x.store = 1'b0; x.size = SCPX_HALF; x.reg_num = 5'h03; x.addr = 32'h0000_2001;
    run(x, st);
    exc_chk(32'h0000_0061);
    idle();
    x = '0; x.valid = 1'b1; x.mfs = 1'b1; x.sel = SEL_EXC_STATUS;
    run(x, st);
    chk("status read", 32'h0000_0061, spr_rdata);
    x.sel = 3'h2;
    run(x, st);
    idle();
    chk("other sel", 32'h0000_0000, spr_rdata);
    // remaining instruction causes, detail bits must be zero
    for (k = 0; k < 3; k++) begin
      x = '0; x.valid = 1'b1; x.reg_num = 5'h1F;
      x.illegal = (k == 0); x.divzero = (k == 1); x.fpu_exc = (k == 2);
      run(x, st);
      exc_chk({27'h0, causes[k]});
      idle();
    end
    // bus error pulses
    ibus_err = 1'b1;
    @(negedge clk);
    ibus_err = 1'b0;
    exc_chk({27'h0, CAUSE_IBUS});
    dbus_err = 1'b1;
    @(negedge clk);
    dbus_err = 1'b0;
    exc_chk({27'h0, CAUSE_DBUS});
    chk("dbus addr", 32'h4000_0010, exc_address);
    chk("return pc", EXC_VECTOR, gpr_wdata);
    // second reset in mid-run clears the status registers
    nrst = 1'b0;
    @(negedge clk);
    chk("status cleared", 32'h0000_0000, exc_status);
    chk("flags cleared", 32'h0000_0000, {27'h0, float_flags});
    nrst = 1'b1;
    @(negedge clk);
    chk("fetch after second reset", 32'h0000_0001, {31'h0, ifetch_req});
    chk("restart pc", RESET_VECTOR, ifetch_addr);
    close_out();
  end
endmodule : test_soft_cpu_pipeline_exception_status
